// file: inc/cfg_cmd_pkg.sv
// Purpose: shared constants and types of the configuration command interpreter
// Assumes: ascii byte stream on the host side, one byte per handshake
// Notes: all numeric arguments and replies are hexadecimal
package cfg_cmd_pkg;
  // characters
  localparam logic [7:0] CHAR_PLUS = 8'h2b;
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_COMMA = 8'h2c;
  localparam logic [7:0] CHAR_A = 8'h41;
  localparam logic [7:0] CHAR_T = 8'h54;
  localparam logic [1:0] PLUS_COUNT_LAST = 2'h2;
  // two-letter command codes as ascii pairs
  localparam logic [15:0] CODE_DEST_LOW = 16'h444c;
  localparam logic [15:0] CODE_BAUD = 16'h4244;
  localparam logic [15:0] CODE_TIMEOUT = 16'h4354;
  localparam logic [15:0] CODE_SAVE = 16'h5752;
  localparam logic [15:0] CODE_RESTORE = 16'h5245;
  localparam logic [15:0] CODE_SWRESET = 16'h4652;
  localparam logic [15:0] CODE_APPLY = 16'h4143;
  localparam logic [15:0] CODE_EXIT = 16'h434e;
  // addressing
  localparam logic [15:0] SHORT_ADDR_USE_LONG = 16'hfffe;
  // factory defaults
  localparam logic [31:0] DEST_DEFAULT = 32'h0000_0000;
  localparam logic [2:0] BAUD_DEFAULT = 3'h3;
  localparam logic [2:0] BAUD_MAX = 3'h7;
  localparam logic [15:0] TIMEOUT_DEFAULT = 16'h0064;
  // remote status codes
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_ERROR = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_PARAM = 8'h03;
  // register offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_DEST = 4'h1;
  localparam logic [3:0] REG_BAUD = 4'h2;
  localparam logic [3:0] REG_TIMEOUT = 4'h3;
  // timing
  localparam int unsigned CLOCK_HZ = 25_000_000;
  localparam int unsigned TIMEOUT_UNIT_MS = 100;
  localparam int unsigned RESET_DELAY_MS = 100;
  localparam int unsigned TICK_CYCLES = CLOCK_HZ / 1000 * TIMEOUT_UNIT_MS;
  localparam int unsigned RESET_DELAY_CYCLES = CLOCK_HZ / 1000 * RESET_DELAY_MS;

  typedef enum logic [3:0] {
    ST_DATA = 4'h0,
    ST_A = 4'h1,
    ST_T = 4'h2,
    ST_C1 = 4'h3,
    ST_C2 = 4'h4,
    ST_ARG = 4'h5,
    ST_EXEC = 4'h6,
    ST_RESP = 4'h7,
    ST_RST = 4'h8
  } state_type;

  typedef enum logic [3:0] {
    CC_DEST = 4'h0,
    CC_BAUD = 4'h1,
    CC_TIMEOUT = 4'h2,
    CC_SAVE = 4'h3,
    CC_RESTORE = 4'h4,
    CC_SWRESET = 4'h5,
    CC_APPLY = 4'h6,
    CC_EXIT = 4'h7,
    CC_BAD = 4'h8
  } cmd_code_type;

  typedef enum logic [1:0] {
    RK_OK = 2'h0,
    RK_ERROR = 2'h1,
    RK_VALUE = 2'h2
  } rsp_kind_type;

  typedef struct packed {
    logic [31:0] dest;
    logic [2:0] baud;
    logic [15:0] timeout;
  } params_type;

  localparam params_type PARAMS_DEFAULT = '{DEST_DEFAULT, BAUD_DEFAULT, TIMEOUT_DEFAULT};
endpackage

// file: logic/config_command_interpreter.sv
// Purpose: text command interpreter and remote configuration handler
// Assumes: host byte stream and radio request/response strobes come from logic on mclk
// Notes: nonvolatile copy is held in flip-flops loaded with factory defaults only by reset_n (power-up)
`timescale 1ns/10ps

module config_command_interpreter #(
  parameter int unsigned TICK_CYCLES = cfg_cmd_pkg::TICK_CYCLES,
  parameter int unsigned RESET_DELAY_CYCLES = cfg_cmd_pkg::RESET_DELAY_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // host byte stream in
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady,
  // host byte stream out
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  // remote configuration request from radio
  input wire logic remReqValid,
  input wire logic [7:0] remFrameId,
  input wire logic [15:0] remShortAddr,
  input wire logic [63:0] remLongAddr,
  input wire logic [15:0] remCmd,
  input wire logic remParamValid,
  input wire logic [31:0] remParam,
  input wire logic remApply,
  // remote response back to radio
  output logic remRspValid,
  output logic [7:0] remRspFrameId,
  output logic [7:0] remRspStatus,
  output logic [31:0] remRspValue,
  output logic remRspUseLong,
  output logic [15:0] remRspShortAddr,
  output logic [63:0] remRspLongAddr,
  // remote response received over radio
  input wire logic radioRspValid,
  input wire logic [7:0] radioRspFrameId,
  input wire logic [7:0] radioRspStatus,
  input wire logic [31:0] radioRspValue,
  // response frame to host
  output logic hostRspValid,
  output logic [7:0] hostRspFrameId,
  output logic [7:0] hostRspStatus,
  output logic [31:0] hostRspValue,
  // active settings
  output logic [2:0] baudSelect,
  output logic [31:0] destAddrLow,
  output logic cmdMode,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData
);

  // counters are 24 bits wide and need at least two states
  if (TICK_CYCLES < 2 || TICK_CYCLES > 32'h00ff_ffff || RESET_DELAY_CYCLES < 2 ||
      RESET_DELAY_CYCLES > 32'h00ff_ffff) begin : g_count_check
    $error("config_command_interpreter: unsupported cycle counts");
  end

  typedef struct packed {
    cfg_cmd_pkg::state_type state;
    cfg_cmd_pkg::state_type afterState;
    logic [1:0] plusCnt;
    logic [15:0] cmd;
    logic [31:0] arg;
    logic [3:0] argCnt;
    logic argBad;
    logic comma;
    cfg_cmd_pkg::rsp_kind_type rspKind;
    logic [31:0] rspVal;
    logic [3:0] rspLen;
    logic [3:0] charIdx;
    logic [23:0] tickCnt;
    logic [15:0] ctCnt;
    logic rstArm;
    logic [23:0] rstCnt;
    cfg_cmd_pkg::params_type active;
    cfg_cmd_pkg::params_type pending;
    cfg_cmd_pkg::params_type saved;
    logic rxReady;
    logic txValid;
    logic [7:0] txData;
    logic remRspValid;
    logic [7:0] remRspFrameId;
    logic [7:0] remRspStatus;
    logic [31:0] remRspValue;
    logic remRspUseLong;
    logic [15:0] remRspShortAddr;
    logic [63:0] remRspLongAddr;
    logic hostRspValid;
    logic [7:0] hostRspFrameId;
    logic [7:0] hostRspStatus;
    logic [31:0] hostRspValue;
    logic [31:0] regRdData;
    logic cmdMode;
  } core_type;

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
  localparam logic [23:0] RESET_LAST = 24'(RESET_DELAY_CYCLES - 1);

  core_type core_reg;
  core_type core_next;

  function automatic cfg_cmd_pkg::cmd_code_type decodeCmd(input logic [15:0] code);
    unique case (code)
      cfg_cmd_pkg::CODE_DEST_LOW: decodeCmd = cfg_cmd_pkg::CC_DEST;
      cfg_cmd_pkg::CODE_BAUD: decodeCmd = cfg_cmd_pkg::CC_BAUD;
      cfg_cmd_pkg::CODE_TIMEOUT: decodeCmd = cfg_cmd_pkg::CC_TIMEOUT;
      cfg_cmd_pkg::CODE_SAVE: decodeCmd = cfg_cmd_pkg::CC_SAVE;
      cfg_cmd_pkg::CODE_RESTORE: decodeCmd = cfg_cmd_pkg::CC_RESTORE;
      cfg_cmd_pkg::CODE_SWRESET: decodeCmd = cfg_cmd_pkg::CC_SWRESET;
      cfg_cmd_pkg::CODE_APPLY: decodeCmd = cfg_cmd_pkg::CC_APPLY;
      cfg_cmd_pkg::CODE_EXIT: decodeCmd = cfg_cmd_pkg::CC_EXIT;
      default: decodeCmd = cfg_cmd_pkg::CC_BAD;
    endcase
  endfunction

  function automatic logic [7:0] upperCase(input logic [7:0] c);
    upperCase = (c >= 8'h61 && c <= 8'h7a) ? (c - 8'h20) : c;
  endfunction

  // hex digit decode: bit 4 marks a valid digit
  function automatic logic [4:0] hexDigit(input logic [7:0] c);
    logic [7:0] u;
    u = upperCase(c);
    if (u >= 8'h30 && u <= 8'h39) begin
      hexDigit = {1'b1, u[3:0]};
    end else if (u >= 8'h41 && u <= 8'h46) begin
      hexDigit = {1'b1, 4'(u[3:0] + 4'h9)};
    end else begin
      hexDigit = 5'h00;
    end
  endfunction

  function automatic logic [3:0] digitCount(input logic [31:0] v);
    digitCount = 4'h1;
    for (int i = 1; i < 8; i++) begin
      if (v[4*i +: 4] != 4'h0) begin
        digitCount = 4'(i + 1);
      end
    end
  endfunction

  function automatic logic [7:0] respChar(input cfg_cmd_pkg::rsp_kind_type kind, input logic [3:0] idx,
                                          input logic [31:0] val, input logic [3:0] len);
    logic [3:0] nib;
    nib = 4'(val >> (4 * (len - idx - 4'h1)));
    if (idx == len) begin
      respChar = cfg_cmd_pkg::CHAR_CR;
    end else begin
      unique case (kind)
        cfg_cmd_pkg::RK_OK: respChar = (idx == 4'h0) ? 8'h4f : 8'h4b;
        cfg_cmd_pkg::RK_ERROR: respChar = (idx == 4'h0 || idx == 4'h3) ? ((idx == 4'h0) ? 8'h45 : 8'h4f) : 8'h52;
        default: respChar = (nib < 4'ha) ? {4'h3, nib} : 8'(8'h37 + {4'h0, nib});
      endcase
    end
  endfunction

  always_comb begin
    cfg_cmd_pkg::cmd_code_type code;
    logic [4:0] hd;
    logic rxFire;
    logic tick;
    logic ok;
    logic query;
    logic [7:0] rstat;
    logic [31:0] rval;
    logic rstReq;
    code = cfg_cmd_pkg::CC_BAD;
    hd = 5'h00;
    ok = 1'b1;
    query = 1'b0;
    rstat = cfg_cmd_pkg::STATUS_OK;
    rstReq = 1'b0;
    rval = 32'h0000_0000;
    core_next = core_reg;
    core_next.remRspValid = 1'b0;
    core_next.hostRspValid = 1'b0;
    rxFire = rxValid && core_reg.rxReady;
    tick = (core_reg.tickCnt == TICK_LAST);
    core_next.tickCnt = tick ? 24'h00_0000 : core_reg.tickCnt + 24'h00_0001;

    // remote configuration request
    if (remReqValid) begin
      code = decodeCmd(remCmd);
      query = !remParamValid;
      unique case (code)
        cfg_cmd_pkg::CC_DEST: begin
          rval = core_reg.pending.dest;
          if (!query) core_next.pending.dest = remParam;
        end
        cfg_cmd_pkg::CC_BAUD: begin
          rval = {29'h0, core_reg.pending.baud};
          if (!query && remParam > {29'h0, cfg_cmd_pkg::BAUD_MAX}) rstat = cfg_cmd_pkg::STATUS_BAD_PARAM;
          else if (!query) core_next.pending.baud = remParam[2:0];
        end
        cfg_cmd_pkg::CC_TIMEOUT: begin
          rval = {16'h0, core_reg.pending.timeout};
          if (!query && (remParam == 32'h0 || remParam[31:16] != 16'h0)) rstat = cfg_cmd_pkg::STATUS_BAD_PARAM;
          else if (!query) core_next.pending.timeout = remParam[15:0];
        end
        cfg_cmd_pkg::CC_SAVE: core_next.saved = core_reg.pending;
        cfg_cmd_pkg::CC_RESTORE: core_next.pending = cfg_cmd_pkg::PARAMS_DEFAULT;
        cfg_cmd_pkg::CC_SWRESET: begin
          core_next.rstArm = 1'b1;
          rstReq = 1'b1;
          core_next.rstCnt = 24'h00_0000;
        end
        cfg_cmd_pkg::CC_APPLY: core_next.active = core_reg.pending;
        cfg_cmd_pkg::CC_EXIT: core_next.active = core_reg.pending;
        default: rstat = cfg_cmd_pkg::STATUS_BAD_CMD;
      endcase
      if ((remApply || code == cfg_cmd_pkg::CC_APPLY) && rstat == cfg_cmd_pkg::STATUS_OK) begin
        core_next.active = core_next.pending;
      end
      if (remFrameId != 8'h00) begin
        core_next.remRspValid = 1'b1;
        core_next.remRspFrameId = remFrameId;
        core_next.remRspStatus = rstat;
        core_next.remRspValue = query ? rval : 32'h0000_0000;
        core_next.remRspUseLong = (remShortAddr == cfg_cmd_pkg::SHORT_ADDR_USE_LONG);
        core_next.remRspShortAddr = remShortAddr;
        core_next.remRspLongAddr = (remShortAddr == cfg_cmd_pkg::SHORT_ADDR_USE_LONG) ? remLongAddr : 64'h0;
      end
    end

    // radio response forwarded to host
    if (radioRspValid && radioRspFrameId != 8'h00) begin
      core_next.hostRspValid = 1'b1;
      core_next.hostRspFrameId = radioRspFrameId;
      core_next.hostRspStatus = radioRspStatus;
      core_next.hostRspValue = radioRspValue;
    end

    if (core_reg.txValid && txReady) core_next.txValid = 1'b0;
    ok = 1'b1;
    query = 1'b0;
    rval = 32'h0000_0000;

    unique case (core_reg.state)
      cfg_cmd_pkg::ST_DATA: begin
        if (rxFire && rxData == cfg_cmd_pkg::CHAR_PLUS) begin
          core_next.plusCnt = core_reg.plusCnt + 2'h1;
          if (core_reg.plusCnt == cfg_cmd_pkg::PLUS_COUNT_LAST) begin
            core_next.plusCnt = 2'h0;
            core_next.ctCnt = 16'h0000;
            core_next.rspKind = cfg_cmd_pkg::RK_OK;
            core_next.rspLen = 4'h2;
            core_next.charIdx = 4'h0;
            core_next.afterState = cfg_cmd_pkg::ST_A;
            core_next.state = cfg_cmd_pkg::ST_RESP;
          end
        end else if (rxFire) begin
          core_next.plusCnt = 2'h0;
        end
      end
      cfg_cmd_pkg::ST_A: begin
        if (rxFire && upperCase(rxData) == cfg_cmd_pkg::CHAR_A) core_next.state = cfg_cmd_pkg::ST_T;
      end
      cfg_cmd_pkg::ST_T: begin
        if (rxFire) begin
          core_next.state = (upperCase(rxData) == cfg_cmd_pkg::CHAR_T) ? cfg_cmd_pkg::ST_C1 : cfg_cmd_pkg::ST_A;
        end
      end
      cfg_cmd_pkg::ST_C1: begin
        if (rxFire) begin
          core_next.cmd[15:8] = upperCase(rxData);
          core_next.state = cfg_cmd_pkg::ST_C2;
        end
      end
      cfg_cmd_pkg::ST_C2: begin
        if (rxFire) begin
          core_next.cmd[7:0] = upperCase(rxData);
          core_next.arg = 32'h0000_0000;
          core_next.argCnt = 4'h0;
          core_next.argBad = 1'b0;
          core_next.state = cfg_cmd_pkg::ST_ARG;
        end
      end
      cfg_cmd_pkg::ST_ARG: begin
        if (rxFire) begin
          hd = hexDigit(rxData);
          if (rxData == cfg_cmd_pkg::CHAR_COMMA || rxData == cfg_cmd_pkg::CHAR_CR) begin
            core_next.comma = (rxData == cfg_cmd_pkg::CHAR_COMMA);
            core_next.state = cfg_cmd_pkg::ST_EXEC;
          end else if (hd[4] && core_reg.argCnt < 4'h8) begin
            core_next.arg = {core_reg.arg[27:0], hd[3:0]};
            core_next.argCnt = core_reg.argCnt + 4'h1;
          end else if (rxData != 8'h20) begin
            core_next.argBad = 1'b1;
          end
        end
      end
      cfg_cmd_pkg::ST_EXEC: begin
        code = decodeCmd(core_reg.cmd);
        query = (core_reg.argCnt == 4'h0);
        ok = !core_reg.argBad;
        core_next.ctCnt = 16'h0000;
        core_next.afterState = core_reg.comma ? cfg_cmd_pkg::ST_C1 : cfg_cmd_pkg::ST_A;
        unique case (code)
          cfg_cmd_pkg::CC_DEST: begin
            rval = core_reg.pending.dest;
            if (!query && ok) core_next.pending.dest = core_reg.arg;
          end
          cfg_cmd_pkg::CC_BAUD: begin
            rval = {29'h0, core_reg.pending.baud};
            if (!query && core_reg.arg > {29'h0, cfg_cmd_pkg::BAUD_MAX}) ok = 1'b0;
            else if (!query && ok) core_next.pending.baud = core_reg.arg[2:0];
          end
          cfg_cmd_pkg::CC_TIMEOUT: begin
            rval = {16'h0, core_reg.pending.timeout};
            if (!query && (core_reg.arg == 32'h0 || core_reg.arg[31:16] != 16'h0)) ok = 1'b0;
            else if (!query && ok) core_next.pending.timeout = core_reg.arg[15:0];
          end
          cfg_cmd_pkg::CC_SAVE: if (ok) core_next.saved = core_reg.pending;
          cfg_cmd_pkg::CC_RESTORE: if (ok) core_next.pending = cfg_cmd_pkg::PARAMS_DEFAULT;
          cfg_cmd_pkg::CC_SWRESET: begin
            if (ok) begin
              core_next.rstArm = 1'b1;
              rstReq = 1'b1;
              core_next.rstCnt = 24'h00_0000;
              core_next.afterState = cfg_cmd_pkg::ST_RST;
            end
          end
          cfg_cmd_pkg::CC_APPLY: if (ok) core_next.active = core_reg.pending;
          cfg_cmd_pkg::CC_EXIT: begin
            if (ok) begin
              core_next.active = core_reg.pending;
              core_next.afterState = cfg_cmd_pkg::ST_DATA;
            end
          end
          default: ok = 1'b0;
        endcase
        query = query && (code == cfg_cmd_pkg::CC_DEST || code == cfg_cmd_pkg::CC_BAUD ||
                          code == cfg_cmd_pkg::CC_TIMEOUT);
        core_next.charIdx = 4'h0;
        core_next.rspVal = rval;
        if (!ok) begin
          core_next.rspKind = cfg_cmd_pkg::RK_ERROR;
          core_next.rspLen = 4'h5;
        end else if (query) begin
          core_next.rspKind = cfg_cmd_pkg::RK_VALUE;
          core_next.rspLen = digitCount(rval);
        end else begin
          core_next.rspKind = cfg_cmd_pkg::RK_OK;
          core_next.rspLen = 4'h2;
        end
        core_next.state = cfg_cmd_pkg::ST_RESP;
      end
      cfg_cmd_pkg::ST_RESP: begin
        if (!core_next.txValid) begin
          core_next.txValid = 1'b1;
          core_next.txData = respChar(core_reg.rspKind, core_reg.charIdx, core_reg.rspVal, core_reg.rspLen);
          if (core_reg.charIdx == core_reg.rspLen) core_next.state = core_reg.afterState;
          else core_next.charIdx = core_reg.charIdx + 4'h1;
        end
      end
      cfg_cmd_pkg::ST_RST: begin
      end
      default: core_next.state = cfg_cmd_pkg::ST_DATA;
    endcase

    // command-mode timeout while waiting for input
    if (core_reg.state inside {cfg_cmd_pkg::ST_A, cfg_cmd_pkg::ST_T, cfg_cmd_pkg::ST_C1,
                               cfg_cmd_pkg::ST_C2, cfg_cmd_pkg::ST_ARG} && tick) begin
      core_next.ctCnt = core_reg.ctCnt + 16'h0001;
      if (core_next.ctCnt >= core_reg.active.timeout) begin
        core_next.state = cfg_cmd_pkg::ST_DATA;
        core_next.plusCnt = 2'h0;
      end
    end

    // delayed software reset reloads the saved copy
    // a new request in the same cycle wins and restarts the delay
    if (core_reg.rstArm && !rstReq) begin
      core_next.rstCnt = core_reg.rstCnt + 24'h00_0001;
      if (core_reg.rstCnt == RESET_LAST && !(core_reg.state == cfg_cmd_pkg::ST_RESP)) begin
        core_next.rstArm = 1'b0;
        core_next.active = core_reg.saved;
        core_next.pending = core_reg.saved;
        core_next.state = cfg_cmd_pkg::ST_DATA;
        core_next.plusCnt = 2'h0;
        core_next.txValid = 1'b0;
      end else if (core_reg.rstCnt == RESET_LAST) begin
        core_next.rstCnt = core_reg.rstCnt;
      end
    end

    // register port
    if (regWrite && regAddr == cfg_cmd_pkg::REG_TIMEOUT && regWrData[15:0] != 16'h0) begin
      core_next.active.timeout = regWrData[15:0];
      core_next.pending.timeout = regWrData[15:0];
    end
    core_next.regRdData = 32'h0000_0000;
    if (regRead) begin
      unique case (regAddr)
        cfg_cmd_pkg::REG_STATUS: core_next.regRdData = {29'h0, core_reg.rstArm, core_reg.active != core_reg.pending,
                                                         core_reg.state != cfg_cmd_pkg::ST_DATA};
        cfg_cmd_pkg::REG_DEST: core_next.regRdData = core_reg.active.dest;
        cfg_cmd_pkg::REG_BAUD: core_next.regRdData = {29'h0, core_reg.active.baud};
        cfg_cmd_pkg::REG_TIMEOUT: core_next.regRdData = {16'h0, core_reg.active.timeout};
        default: core_next.regRdData = 32'h0000_0000;
      endcase
    end

    core_next.rxReady = core_next.state inside {cfg_cmd_pkg::ST_DATA, cfg_cmd_pkg::ST_A, cfg_cmd_pkg::ST_T,
                                                cfg_cmd_pkg::ST_C1, cfg_cmd_pkg::ST_C2, cfg_cmd_pkg::ST_ARG};
    core_next.cmdMode = (core_next.state != cfg_cmd_pkg::ST_DATA);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      core_reg <= '0;
      core_reg.state <= cfg_cmd_pkg::ST_DATA;
      core_reg.afterState <= cfg_cmd_pkg::ST_DATA;
      core_reg.active <= cfg_cmd_pkg::PARAMS_DEFAULT;
      core_reg.pending <= cfg_cmd_pkg::PARAMS_DEFAULT;
      core_reg.saved <= cfg_cmd_pkg::PARAMS_DEFAULT;
    end else begin
      core_reg <= core_next;
    end
  end

  assign rxReady = core_reg.rxReady;
  assign txValid = core_reg.txValid;
  assign txData = core_reg.txData;
  assign remRspValid = core_reg.remRspValid;
  assign remRspFrameId = core_reg.remRspFrameId;
  assign remRspStatus = core_reg.remRspStatus;
  assign remRspValue = core_reg.remRspValue;
  assign remRspUseLong = core_reg.remRspUseLong;
  assign remRspShortAddr = core_reg.remRspShortAddr;
  assign remRspLongAddr = core_reg.remRspLongAddr;
  assign hostRspValid = core_reg.hostRspValid;
  assign hostRspFrameId = core_reg.hostRspFrameId;
  assign hostRspStatus = core_reg.hostRspStatus;
  assign hostRspValue = core_reg.hostRspValue;
  assign baudSelect = core_reg.active.baud;
  assign destAddrLow = core_reg.active.dest;
  assign cmdMode = core_reg.cmdMode;
  assign regRdData = core_reg.regRdData;

endmodule // config_command_interpreter

// file: verif/cfg_cmd_monitor.sv
// Purpose: port checker for the command interpreter
// Assumes: one clock, bound into every interpreter
// Notes: sees port signals only
`timescale 1ns/10ps
module cfg_cmd_monitor (
  // remote side
  input logic mclk, reset_n, remReqValid, remParamValid, remApply, remRspValid, remRspUseLong,
  input logic [7:0] remFrameId, remRspFrameId,
  input logic [15:0] remShortAddr, remCmd,
  input logic [63:0] remRspLongAddr,
  // radio, host and settings
  input logic radioRspValid, hostRspValid, txValid, txReady,
  input logic [7:0] radioRspFrameId, radioRspStatus, hostRspStatus, txData,
  input logic [2:0] baudSelect
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire remReq = remReqValid && remFrameId != 8'h00;
  wire useLong = remShortAddr == cfg_cmd_pkg::SHORT_ADDR_USE_LONG;
  property p_reply; remReq |=> remRspValid && remRspFrameId == $past(remFrameId); endproperty
  a_reply: assert property (p_reply) else $error("missing remote reply");
  property p_silent; remReqValid && remFrameId == 8'h00 |=> !remRspValid; endproperty
  a_silent: assert property (p_silent) else $error("reply to zero frame id");
  property p_long; remReq && useLong |=> remRspUseLong; endproperty
  a_long: assert property (p_long) else $error("long address not used");
  property p_short; remReq && !useLong |=> !remRspUseLong && remRspLongAddr == 64'h0; endproperty
  a_short: assert property (p_short) else $error("long address not ignored");
  property p_fwd; radioRspValid && radioRspFrameId != 8'h00 |=> hostRspValid && hostRspStatus == $past(radioRspStatus);
  endproperty
  a_fwd: assert property (p_fwd) else $error("radio reply not forwarded");
  property p_pend; remReqValid && remParamValid && !remApply && remCmd == cfg_cmd_pkg::CODE_BAUD |=> $stable(baudSelect)[*2];
  endproperty
  a_pend: assert property (p_pend) else $error("pending value took effect");
  property p_hold; txValid && !txReady |=> txValid && $stable(txData); endproperty
  a_hold: assert property (p_hold) else $error("reply byte dropped");
  property p_boot; $rose(reset_n) |-> baudSelect == cfg_cmd_pkg::BAUD_DEFAULT; endproperty
  a_boot: assert property (p_boot) else $error("baud not default after reset");
  c_reply: cover property (remReq ##1 remRspValid);
  c_fwd: cover property (hostRspValid);
  c_stall: cover property (txValid && !txReady);
endmodule // cfg_cmd_monitor
bind config_command_interpreter cfg_cmd_monitor mon (.*);

// file: verif/host_serial_model.sv
// Purpose: host reply sink
// Assumes: reply bytes on a valid/ready pair
// Notes: stalls every other cycle when slow
`timescale 1ns/10ps
module host_serial_model (
  input logic mclk, reset_n, slow, txValid,
  input logic [7:0] txData,
  output logic txReady, gotByte,
  output logic [7:0] gotData
);
  logic phase;
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) phase <= 1'b0;
    else phase <= !phase;
  assign txReady = !slow || phase;
  assign gotByte = txValid && txReady;
  assign gotData = txData;
endmodule // host_serial_model

// file: verif/tb_top.sv
// Purpose: self-checking bench of the interpreter
// Assumes: short tick and reset counts
// Notes: reset baud check, then rows, then hand tests
`timescale 1ns/10ps
module tb_top;
  logic mclk = 0, reset_n = 0, rxValid = 0, slow = 0, remReqValid = 0, remParamValid = 0, remApply = 0;
  logic radioRspValid = 0, regWrite = 0, regRead = 0, rxReady, txValid, txReady, gotByte, remRspValid;
  logic remRspUseLong, hostRspValid, cmdMode;
  logic [7:0] rxData = 0, remFrameId = 0, radioRspFrameId = 0, radioRspStatus = 0, txData, gotData;
  logic [7:0] remRspFrameId, remRspStatus, hostRspFrameId, hostRspStatus;
  logic [15:0] remShortAddr = 0, remCmd = cfg_cmd_pkg::CODE_BAUD, remRspShortAddr;
  logic [31:0] remParam = 0, radioRspValue = 0, regWrData = 0, remRspValue, hostRspValue, destAddrLow, regRdData;
  logic [63:0] remLongAddr = 64'h0123_4567_89ab_cdef, remRspLongAddr;
  logic [3:0] regAddr = 0;
  logic [2:0] baudSelect;
  logic [95:0] rep;
  int num_errors = 0, n_compared = 0;
  typedef struct {string c; int n; logic [95:0] r;} row_type;
  row_type rows[7] = '{'{"+++", 1, "OK\r"}, '{"ATBD\r", 1, "3\r"}, '{"ATBD8\r", 1, "ERROR\r"},
    '{"ATCT0\r", 1, "ERROR\r"}, '{"ATDL1A0D\r", 1, "OK\r"}, '{"ATDL\r", 1, "1A0D\r"},
    '{"atBD5,WR,CN\r", 3, "OK\rOK\rOK\r"}};
  config_command_interpreter #(.TICK_CYCLES(10), .RESET_DELAY_CYCLES(20)) dut (.*);
  host_serial_model host (.*);
  initial forever #20 mclk = ~mclk;
  task print_verdict;
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [95:0] got, input logic [95:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      rxData <= s[i];
      rxValid <= 1'b1;
      @(negedge mclk);
      while (!rxReady) @(negedge mclk);
      @(posedge mclk);
    end
    rxValid <= 1'b0;
  endtask
  task get(input int n);
    rep = '0;
    while (n > 0) begin
      @(negedge mclk);
      if (gotByte === 1'b1) begin
        rep = {rep[87:0], gotData};
        if (gotData == 8'h0d) n--;
      end
    end
  endtask
  task cmd(input string s, input int n, input logic [95:0] r);
    @(posedge mclk);
    fork send(s); get(n); join
    chk(rep, r);
  endtask
  task rem(input logic [7:0] f, input logic [15:0] a, input logic pv, input logic ap, input logic [31:0] p);
    @(posedge mclk);
    {remReqValid, remFrameId, remShortAddr, remParamValid, remApply, remParam} <= {1'b1, f, a, pv, ap, p};
    @(posedge mclk);
    remReqValid <= 1'b0;
    #1;
  endtask
  task rg(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    {regWrite, regRead, regAddr, regWrData} <= {w, !w, a, d};
    @(posedge mclk);
    {regWrite, regRead} <= 2'b00;
    #1;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk(baudSelect, 3);
    foreach (rows[i]) cmd(rows[i].c, rows[i].n, rows[i].r);
    chk({baudSelect, destAddrLow, cmdMode}, {3'h5, 32'h1a0d, 1'b0});
    rem(8'h05, 16'h1234, 0, 0, 0);
    chk({remRspValid, remRspStatus, remRspValue, remRspUseLong}, {1'b1, 8'h00, 32'h5, 1'b0});
    chk({remRspFrameId, remRspShortAddr}, {8'h05, 16'h1234});
    rem(8'h00, 16'h1234, 1, 0, 32'h2);
    chk(remRspValid, 0);
    repeat (3) @(posedge mclk);
    #1 chk(baudSelect, 5);
    rem(8'h07, 16'hfffe, 1, 1, 32'h2);
    chk({remRspUseLong, remRspLongAddr}, {1'b1, remLongAddr});
    repeat (3) @(posedge mclk);
    #1 chk(baudSelect, 2);
    @(posedge mclk);
    {radioRspValid, radioRspFrameId, radioRspStatus, radioRspValue} <= {1'b1, 8'h09, 8'h03, 32'hbeef};
    @(posedge mclk);
    radioRspValid <= 1'b0;
    #1 chk({hostRspValid, hostRspFrameId, hostRspStatus, hostRspValue}, {1'b1, 8'h09, 8'h03, 32'hbeef});
    cmd("+++", 1, "OK\r");
    cmd("ATFR\r", 1, "OK\r");
    chk(baudSelect, 2);
    repeat (40) @(posedge mclk);
    slow <= 1'b1;
    #1 chk({baudSelect, destAddrLow, cmdMode}, {3'h5, 32'h1a0d, 1'b0});
    cmd("+++", 1, "OK\r");
    cmd("ATRE,AC\r", 2, "OK\rOK\r");
    chk({baudSelect, destAddrLow}, {3'h3, 32'h0});
    cmd("ATCN\r", 1, "OK\r");
    rg(0, cfg_cmd_pkg::REG_BAUD, 0);
    chk(regRdData, 3);
    rg(0, 4'hf, 0);
    chk(regRdData, 0);
    rg(1, cfg_cmd_pkg::REG_TIMEOUT, 2);
    rg(0, cfg_cmd_pkg::REG_TIMEOUT, 0);
    chk(regRdData, 2);
    cmd("+++", 1, "OK\r");
    repeat (40) @(posedge mclk);
    #1 chk(cmdMode, 0);
    print_verdict;
  end
endmodule // tb_top
